//--- design/wdc_pkg.sv
// ==========================================================
// shared constants and carriers for the watchdog control
// ==========================================================
package wdc_pkg;

  // ========================================================
  // clocks and timing
  // ========================================================
  localparam int unsigned CLK_HZ = 10_000_000; // ref_clk rate
  localparam int unsigned OSC_HZ = 128_000; // watchdog oscillator
  localparam logic [2:0] CE_WINDOW = 3'h4; // change window, clocks

  // ========================================================
  // register map
  // ========================================================
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_RSRC = 4'h1;

  // watchdog_control field positions
  localparam int BIT_IRQ_FLAG = 7;
  localparam int BIT_IRQ_EN = 6;
  localparam int BIT_SEL_MSB = 5;
  localparam int BIT_CE = 4;
  localparam int BIT_RST_EN = 3;
  localparam int BIT_SEL_LO = 2;
  // reset_source_register field position
  localparam int BIT_WRF = 3;

  // ========================================================
  // time-out selection
  // ========================================================
  localparam int CNT_W = 21;
  localparam logic [CNT_W-1:0] TIMEOUT_BASE = 21'h000800; // 2048
  localparam logic [3:0] SEL_MAX = 4'h9; // 1048576 cycles

  // ========================================================
  // types
  // ========================================================
  // action decode, gray along stopped-int-combined-reset
  typedef enum logic [1:0] {
    MODE_STOPPED = 2'b00,
    MODE_INT = 2'b01,
    MODE_COMBINED = 2'b11,
    MODE_RESET = 2'b10
  } wdc_mode_e;

  // register port from the core
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } wdc_bus_s;

  // core side events and levels
  typedef struct packed {
    logic gie; // global interrupt enable of cpu_status_register
    logic vector_taken; // watchdog vector executed, one cycle
    logic restart; // restart instruction executed, one cycle
  } wdc_cpu_s;

endpackage

//--- design/wdc_osc_sync.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// oscillator pin synchroniser and rising edge tick
// ==========================================================
module wdc_osc_sync
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // pin side
  input wire logic async_in,
  // core side
  output var logic tick
);

  typedef struct packed {
    logic [2:0] sync;
    logic level;
    logic tick;
  } wdc_sync_s;

  wdc_sync_s st;
  wdc_sync_s next_st;

  // a change counts only once stages two and three agree
  always_comb
  begin
    next_st = st;
    next_st.sync = {st.sync[1:0], async_in};
    next_st.tick = 1'b0;
    if ((st.sync[1] == st.sync[2]) && (st.sync[2] != st.level))
    begin
      next_st.level = st.sync[2];
      next_st.tick = st.sync[2]; // rising edges only
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      st <= '0;
    else
      st <= next_st;
  end

  assign tick = st.tick;

endmodule
`default_nettype wire

//--- design/wdc_watchdog.sv
// Behaviour
// R1: software restarts the counter before shortening the time-out select
// R2: flag bit 7 sets on time-out when interrupt operation is configured
// R3: flag clears on vector execution or by writing one to it
// R4: interrupt requested only when global and bit 6 enables both set
// R5: enable set, reset enable clear: interrupt on every time-out
// R6: combined mode: flag first; vector clears enable and flag, reset next
// R7: software re-arms interrupt enable after each interrupt, not in handler
// R8: fuse unprogrammed: reset/irq enables 00 stop,01 irq,10 reset,11 both
// R9: fuse programmed: system reset on every time-out regardless of enables
// R10: reset enable clear or select change only while change enable set
// R11: change enable clears itself four clocks after being written one
// R12: bit 3 reads set while reset flag set; cannot clear before it
// R13: select msb at control bit 5, low three bits at bits 2..0
// R14: select 0000 gives 2048 cycles, doubling to 1001; 1010+ reserved
// R15: counts 128 kHz oscillator cycles; restart instruction zeroes it
// R16: software writes change and reset enables, then settings within four
// R17: fuse programmed holds reset enable at 1, interrupt enable at 0
// R18: watchdog reset sets reset flag; power-on or zero write clears it
`timescale 1ns/1ns
`default_nettype none
module wdc_watchdog
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // register port
  input wire wdc_pkg::wdc_bus_s bus,
  output var logic [7:0] rd_data,
  // core events
  input wire wdc_pkg::wdc_cpu_s cpu,
  output var logic irq_req,
  output var logic sys_reset,
  // fuse and oscillator pins
  input wire logic always_on_fuse,
  input wire logic wdt_osc
);
  import wdc_pkg::*;

  // ========================================================
  // state
  // ========================================================
  typedef struct packed {
    logic irq_flag;
    logic irq_en;
    logic ce;
    logic rst_en;
    logic [3:0] sel;
    logic [2:0] ce_cnt;
    logic wrf;
    logic fuse_prog;
    logic [CNT_W-1:0] count;
    logic irq_req;
    logic sys_reset;
    logic [7:0] rd_data;
  } wdc_state_s;

  wdc_state_s st;
  wdc_state_s next_st;

  logic tick;
  logic ctrl_wr;
  logic rsrc_wr;
  logic rst_mode;
  logic int_mode;
  logic timeout;
  logic ce_arm;
  logic [3:0] sel_eff;
  logic [CNT_W-1:0] terminal;
  wdc_mode_e mode;

  // ========================================================
  // oscillator tick
  // ========================================================
  wdc_osc_sync u_osc_sync
  (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .async_in(wdt_osc),
    .tick(tick)
  );

  // ========================================================
  // decode
  // ========================================================
  // register strobes
  assign ctrl_wr = bus.wr && (bus.addr == ADDR_CTRL);
  assign rsrc_wr = bus.wr && (bus.addr == ADDR_RSRC);
  // sequence opener needs both change and reset enable in one write
  assign ce_arm = ctrl_wr && bus.wdata[BIT_CE]
    && bus.wdata[BIT_RST_EN]; // R16

  // effective enables; the reset flag and the fuse override
  assign rst_mode = st.rst_en | st.wrf | st.fuse_prog; // R9 R12
  assign int_mode = st.irq_en & ~st.fuse_prog; // R9

  // action decode
  always_comb
  begin
    case ({rst_mode, int_mode}) // R8
      2'b00: mode = MODE_STOPPED;
      2'b01: mode = MODE_INT;
      2'b10: mode = MODE_RESET;
      2'b11: mode = MODE_COMBINED;
      default: mode = MODE_STOPPED;
    endcase
  end

  // reserved codes fall back to the longest period
  assign sel_eff = (st.sel > SEL_MAX) ? SEL_MAX : st.sel; // R14
  assign terminal = (TIMEOUT_BASE << sel_eff) - 21'h1; // R14

  // >= so that a shorter select expires at once, hence restart first
  assign timeout = tick && (mode != MODE_STOPPED)
    && (st.count >= terminal); // R1 R15

  // ========================================================
  // next state
  // ========================================================
  always_comb
  begin
    next_st = st;
    next_st.fuse_prog = ~always_on_fuse; // fuse 0 means programmed
    next_st.sys_reset = 1'b0;

    // oscillator counter, zeroed by restart, time-out or stop
    if (cpu.restart || (mode == MODE_STOPPED) || timeout)
      next_st.count = '0; // R15
    else if (tick)
      next_st.count = st.count + 21'h1; // R15

    // change window runs down on every clock
    if (st.ce_cnt != 3'h0)
    begin
      next_st.ce_cnt = st.ce_cnt - 3'h1;
      if (st.ce_cnt == 3'h1)
        next_st.ce = 1'b0; // R11
    end

    // control register write
    if (ctrl_wr)
    begin
      if (bus.wdata[BIT_IRQ_FLAG])
        next_st.irq_flag = 1'b0; // R3
      next_st.irq_en = bus.wdata[BIT_IRQ_EN];
      // setting reset enable is always free, clearing is guarded
      if (bus.wdata[BIT_RST_EN] || (st.ce && !st.wrf))
        next_st.rst_en = bus.wdata[BIT_RST_EN]; // R10 R12
      if (st.ce)
        next_st.sel = {bus.wdata[BIT_SEL_MSB],
          bus.wdata[BIT_SEL_LO:0]}; // R10 R13
      // any write ends the window, an opener restarts it
      next_st.ce = ce_arm;
      next_st.ce_cnt = ce_arm ? CE_WINDOW : 3'h0; // R11
    end

    // reset source write, zero clears the flag
    if (rsrc_wr && !bus.wdata[BIT_WRF])
      next_st.wrf = 1'b0; // R18

    // vector execution
    if (cpu.vector_taken)
    begin
      next_st.irq_flag = 1'b0; // R3
      if (rst_mode)
        next_st.irq_en = 1'b0; // R6
    end

    // time-out action, placed last so a set beats any clear
    if (timeout)
    begin
      case (mode)
        MODE_INT: next_st.irq_flag = 1'b1; // R2 R5
        MODE_COMBINED:
        begin
          // a still pending interrupt means nobody answered
          if (st.irq_flag)
          begin
            next_st.sys_reset = 1'b1;
            next_st.wrf = 1'b1; // R18
          end
          else
            next_st.irq_flag = 1'b1; // R2 R6
        end
        MODE_RESET:
        begin
          next_st.sys_reset = 1'b1; // R9
          next_st.wrf = 1'b1; // R18
        end
        default: next_st.sys_reset = 1'b0;
      endcase
    end

    // reset flag holds reset enable high
    if (next_st.wrf)
      next_st.rst_en = 1'b1; // R12

    // fuse lock wins over any write
    if (st.fuse_prog)
    begin
      next_st.irq_en = 1'b0; // R17
      next_st.rst_en = 1'b1; // R17
    end

    // interrupt request to the core
    next_st.irq_req = st.irq_flag & int_mode & cpu.gie; // R4

    // read data stands only in the cycle after the strobe
    next_st.rd_data = 8'h00;
    if (bus.rd)
    begin
      case (bus.addr)
        ADDR_CTRL:
        begin
          next_st.rd_data[BIT_IRQ_FLAG] = st.irq_flag;
          next_st.rd_data[BIT_IRQ_EN] = st.irq_en;
          next_st.rd_data[BIT_SEL_MSB] = st.sel[3]; // R13
          next_st.rd_data[BIT_CE] = st.ce;
          next_st.rd_data[BIT_RST_EN] = st.rst_en | st.wrf; // R12
          next_st.rd_data[BIT_SEL_LO:0] = st.sel[2:0]; // R13
        end
        ADDR_RSRC: next_st.rd_data[BIT_WRF] = st.wrf;
        default: next_st.rd_data = 8'h00;
      endcase
    end
  end

  // ========================================================
  // registers
  // ========================================================
  // the fuse is sampled after release, reset loads constants only
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      st <= '0;
    else
      st <= next_st;
  end

  assign rd_data = st.rd_data;
  assign irq_req = st.irq_req;
  assign sys_reset = st.sys_reset;

  // ========================================================
  // checks
  // ========================================================
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  // a fresh opener, then four quiet clocks
  sequence s_ce_arm;
    ce_arm;
  endsequence

  sequence s_ce_quiet;
    (!ctrl_wr && st.ce)[*4];
  endsequence

  AST_CE_CLEARS: assert property ( // R11
    s_ce_arm ##1 s_ce_quiet |=> !st.ce)
    else $error("change enable not cleared after four clocks");

  AST_CE_HOLDS: assert property ( // R11
    s_ce_arm |=> st.ce && (st.ce_cnt == CE_WINDOW))
    else $error("change enable not opened by opener write");

  AST_SEL_LOCKED: assert property ( // R10
    ctrl_wr && !st.ce |=> $stable(st.sel))
    else $error("select changed without change enable");

  AST_RST_EN_GUARD: assert property ( // R10
    ctrl_wr && !st.ce && st.rst_en |=> st.rst_en)
    else $error("reset enable cleared without change enable");

  AST_WRF_HOLDS_RST: assert property ( // R12
    st.wrf |=> st.rst_en)
    else $error("reset enable clear while reset flag set");

  AST_FUSE_LOCK: assert property ( // R17
    st.fuse_prog |=> !st.irq_en && st.rst_en)
    else $error("fuse did not lock the enables");

  AST_IRQ_GATE: assert property ( // R4
    irq_req |-> $past(st.irq_flag && cpu.gie && int_mode))
    else $error("interrupt requested without both enables");

  AST_INT_MODE: assert property ( // R5
    timeout && (mode == MODE_INT) |=> st.irq_flag && !sys_reset)
    else $error("interrupt mode time-out did not set only the flag");

  AST_RESET_MODE: assert property ( // R9
    timeout && (mode == MODE_RESET) |=> sys_reset && st.wrf
    ##1 !sys_reset)
    else $error("reset mode time-out did not give one reset pulse");

  AST_VECTOR: assert property ( // R6
    cpu.vector_taken && rst_mode && !timeout && !st.fuse_prog
    |=> !st.irq_en && !st.irq_flag)
    else $error("vector did not drop enable and flag");

  AST_STOPPED: assert property ( // R8
    (mode == MODE_STOPPED) |=> !sys_reset && (st.count == '0))
    else $error("stopped watchdog acted or counted");

  AST_RESTART: assert property ( // R15
    cpu.restart |=> (st.count == '0))
    else $error("restart did not zero the counter");

  AST_WRF_CLEAR: assert property ( // R18
    rsrc_wr && !bus.wdata[BIT_WRF] && !timeout |=> !st.wrf)
    else $error("reset flag not cleared by zero write");

  AST_FLAG_W1C: assert property ( // R3
    ctrl_wr && bus.wdata[BIT_IRQ_FLAG] && !timeout |=> !st.irq_flag)
    else $error("flag not cleared by a write of one");

  AST_COMBINED_FIRST: assert property ( // R6
    timeout && (mode == MODE_COMBINED) && !st.irq_flag
    |=> st.irq_flag && !sys_reset)
    else $error("combined mode first time-out did not set the flag");

  AST_SEL_LOAD: assert property ( // R10 R13
    ctrl_wr && st.ce |=> (st.sel[3] == $past(bus.wdata[BIT_SEL_MSB]))
    && (st.sel[2:0] == $past(bus.wdata[BIT_SEL_LO:0])))
    else $error("select not loaded inside the change window");

  AST_WINDOW_ENDS: assert property ( // R16
    ctrl_wr && !(bus.wdata[BIT_CE] && bus.wdata[BIT_RST_EN])
    |=> !st.ce)
    else $error("change window survived a plain control write");

  AST_IRQ_DROP: assert property ( // R4
    !cpu.gie |=> !irq_req)
    else $error("interrupt requested with global enable low");

  AST_RST_PULSE: assert property ( // R9
    sys_reset |=> !sys_reset)
    else $error("system reset wider than one clock");

  AST_WRF_ON_RESET: assert property ( // R18
    sys_reset |-> st.wrf)
    else $error("reset issued without setting the reset flag");

endmodule
`default_nettype wire

//--- dv/wdc_core_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// processor core model: takes the watchdog vector
// ==========================================================
module wdc_core_model
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // bench controls
  input wire logic gie_en,
  input wire logic restart_cmd,
  input wire logic [3:0] lat,
  // watchdog side
  input wire logic irq_req,
  output var wdc_pkg::wdc_cpu_s cpu
);
  import wdc_pkg::*;
  logic [1:0] st;
  logic [3:0] cnt;
  logic vt;
  // handler entry drops the global enable, as a real core does
  assign cpu = {gie_en && (st == 2'h0), vt, restart_cmd};
  // idle, wait lat clocks, then vector pulse and a short return
  always_ff @(posedge ref_clk)
  begin
    vt <= 1'b0;
    if (!rstn)
    begin
      st <= 2'h0;
      cnt <= 4'h0;
    end
    else if (st == 2'h0)
    begin
      if (irq_req && cpu.gie)
      begin
        st <= 2'h1;
        cnt <= lat;
      end
    end
    else if (cnt != 4'h0)
      cnt <= cnt - 4'h1;
    else if (st == 2'h1)
    begin
      vt <= 1'b1;
      st <= 2'h2;
      cnt <= 4'h3;
    end
    else
      st <= 2'h0; // handler never re-arms the enable
  end
endmodule
`default_nettype wire

//--- dv/tb_watchdog_timer_control.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// bench: register calls against expected values
// ==========================================================
module tb_watchdog_timer_control;
  import wdc_pkg::*;
  logic ref_clk, rstn, fuse, osc, gie_en, rs_cmd, irq_req, sys_reset;
  logic [3:0] lat;
  logic [7:0] rd_data, d;
  wdc_bus_s bus;
  wdc_cpu_s cpu;
  int err_total, n_tests, cyc, rst_cnt, i;

  wdc_watchdog uut (.ref_clk(ref_clk), .rstn(rstn), .bus(bus),
    .rd_data(rd_data), .cpu(cpu), .irq_req(irq_req),
    .sys_reset(sys_reset), .always_on_fuse(fuse), .wdt_osc(osc));
  wdc_core_model core (.ref_clk(ref_clk), .rstn(rstn), .gie_en(gie_en),
    .restart_cmd(rs_cmd), .lat(lat), .irq_req(irq_req), .cpu(cpu));

  // ==========================================================
  // clocks: osc ticks every 8 clocks, phase unrelated
  // ==========================================================
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial
  begin
    osc = 1'b0;
    #37;
    forever #400 osc = ~osc;
  end
  // reset pulse count and hang guard, four time-outs fit well
  always @(posedge ref_clk)
  begin
    cyc++;
    if (sys_reset === 1'b1)
      rst_cnt++;
    if (cyc == 90000)
    begin
      err_total++;
      results();
    end
  end

  // ==========================================================
  // bus tasks and compare
  // ==========================================================
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= v;
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    #1 d = rd_data;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    rd(a);
    chk(d, e);
  endtask
  // bounded wait for irq_req (sel 0) or sys_reset (sel 1)
  task automatic wait_ev(input logic sel);
    for (i = 0; i < 20000; i++)
    begin
      @(posedge ref_clk);
      #1;
      if ((sel ? sys_reset : irq_req) === 1'b1)
        break;
    end
  endtask
  task automatic restart();
    @(posedge ref_clk);
    rs_cmd <= 1'b1;
    @(posedge ref_clk);
    rs_cmd <= 1'b0;
  endtask
  task automatic tend(input string s);
    $display("test %s done", s);
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  // ==========================================================
  initial
  begin
    bus = '0;
    rstn = 1'b0;
    fuse = 1'b1;
    gie_en = 1'b0;
    rs_cmd = 1'b0;
    lat = 4'h0;
    err_total = 0;
    n_tests = 0;
    cyc = 0;
    rst_cnt = 0;
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    rchk(ADDR_CTRL, 8'h00);
    rchk(ADDR_RSRC, 8'h00);
    wr(4'h7, 8'hff);
    rchk(4'h7, 8'h00);
    wr(ADDR_CTRL, 8'h27);
    rchk(ADDR_CTRL, 8'h00);
    tend("reset");
    wr(ADDR_CTRL, 8'h18);
    rchk(ADDR_CTRL, 8'h18);
    repeat (4) @(posedge ref_clk);
    rchk(ADDR_CTRL, 8'h08);
    restart();
    wr(ADDR_CTRL, 8'h18);
    wr(ADDR_CTRL, 8'h21);
    rchk(ADDR_CTRL, 8'h21);
    wr(ADDR_CTRL, 8'h18);
    wr(ADDR_CTRL, 8'h00);
    rchk(ADDR_CTRL, 8'h00);
    tend("change");
    // interrupt mode with the global enable low: flag only
    wr(ADDR_CTRL, 8'h40);
    // 2048 ticks of 8 clocks need more than 8192 two-clock reads
    for (int k = 0; k < 10000; k++)
    begin
      rd(ADDR_CTRL);
      if (d[7] === 1'b1)
        break;
    end
    chk(d, 8'hc0);
    chk({7'h0, irq_req}, 8'h00);
    wr(ADDR_CTRL, 8'hc0);
    rchk(ADDR_CTRL, 8'h40);
    @(posedge ref_clk);
    gie_en <= 1'b1;
    wait_ev(1'b0);
    chk({7'h0, irq_req}, 8'h01);
    repeat (6) @(posedge ref_clk);
    rchk(ADDR_CTRL, 8'h40);
    chk(rst_cnt[7:0], 8'h00);
    tend("interrupt");
    // combined mode with a slow handler
    restart();
    lat <= 4'h5;
    wr(ADDR_CTRL, 8'h48);
    wait_ev(1'b0);
    chk({7'h0, irq_req}, 8'h01);
    repeat (12) @(posedge ref_clk);
    rchk(ADDR_CTRL, 8'h08);
    wait_ev(1'b1);
    // the pulse is counted one edge after it is seen, so read first
    rchk(ADDR_RSRC, 8'h08);
    chk(rst_cnt[7:0], 8'h01);
    wr(ADDR_CTRL, 8'h18);
    wr(ADDR_CTRL, 8'h00);
    rchk(ADDR_CTRL, 8'h08);
    wr(ADDR_RSRC, 8'h00);
    rchk(ADDR_RSRC, 8'h00);
    wr(ADDR_CTRL, 8'h18);
    wr(ADDR_CTRL, 8'h00);
    rchk(ADDR_CTRL, 8'h00);
    tend("combined");
    // programmed fuse, applied across a second reset
    @(posedge ref_clk);
    rstn <= 1'b0;
    fuse <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    wr(ADDR_CTRL, 8'h40);
    rchk(ADDR_CTRL, 8'h08);
    wr(ADDR_CTRL, 8'h18);
    wr(ADDR_CTRL, 8'h00);
    rchk(ADDR_CTRL, 8'h08);
    tend("fuse");
    results();
  end
endmodule
`default_nettype wire
